// [rtl/bus_agent_consts.vh]
`ifndef BUS_AGENT_CONSTS_VH
`define BUS_AGENT_CONSTS_VH

// Transfer kind codes, {hi, lo}
`define KIND_ADDR_ONLY     2'h0
`define KIND_RSVD          2'h1
`define KIND_NONSEQ        2'h2
`define KIND_SEQ           2'h3

// Select and lock idle levels, and the one-hot select seed
`define CS_ALL_IDLE        8'hFF
`define CS_ONE_HOT         8'h01
`define LOCK_IDLE          1'b0
`define PSEL_IDLE          1'b1

// Timing
`define CLK_PERIOD_NS      25
`define CORE_RST_BUS_CLKS  8'h10
`define CORE_RST_CNT_W     8

// Slave response defaults
`define SLV_WAITS_DEF      2
`define SLV_DEPTH_DEF      16
`define SLV_AW_DEF         4

`endif

// [rtl/bus_slave_resp.v]
`timescale 1ns/1ps
`include "bus_agent_consts.vh"

module bus_slave_resp #(
   parameter WAITS    = `SLV_WAITS_DEF,
   parameter USE_HOLD = 1,
   parameter DEPTH    = `SLV_DEPTH_DEF,
   parameter AW       = `SLV_AW_DEF,
   parameter BANK     = 0
) (
   input  wire        clk,
   input  wire        srst,
   input  wire        rise,
   input  wire        fall,
   input  wire [1:0]  kind,
   input  wire        dir,
   input  wire [27:0] addr,
   input  wire [7:0]  cs_n,
   input  wire [31:0] data_in,
   output reg         wait_q,
   output reg         hold_q,
   output reg         last_q,
   output reg  [31:0] rdata_q,
   output reg         rdata_oe_q
);

   localparam [1:0] S_IDLE = 2'h1;
   localparam [1:0] S_BUSY = 2'h2;
   localparam integer WAIT_LAST_I = WAITS - 1;
   localparam [7:0]   WAIT_LAST   = WAIT_LAST_I[7:0];

   reg  [1:0]    st_q;
   reg  [7:0]    cnt_q;
   reg  [AW-1:0] idx_q;
   reg           wr_q;
   reg           wr_pend_q;
   reg  [31:0]   mem_q [0:DEPTH-1];

   // Only data-carrying kinds open a transfer; address-only is ignored
   wire          sel      = (cs_n[BANK] == 1'b0) && kind[1];
   wire [AW-1:0] aidx     = addr[AW+1:2];
   wire          busy     = (st_q == S_BUSY);
   wire          resp_now = rise && ((!busy && sel && (WAITS == 0)) ||
                                     (busy && (cnt_q == 8'h00)));
   wire [AW-1:0] resp_idx = busy ? idx_q : aidx;
   wire          resp_wr  = busy ? wr_q : dir;

   // Response sequencer, all changes on bus clock rising edges
   always @(posedge clk) begin
      if (srst) begin
         st_q       <= S_IDLE;
         cnt_q      <= 8'h00;
         idx_q      <= {AW{1'b0}};
         wr_q       <= 1'b0;
         wait_q     <= 1'b0;
         hold_q     <= 1'b0;
         last_q     <= 1'b0;
         rdata_q    <= 32'h0;
         rdata_oe_q <= 1'b0;
      end else if (rise) begin
         rdata_oe_q <= 1'b0;
         last_q     <= 1'b0;                // Bursts answered with plain ready [R21]
         if (resp_now) begin
            wait_q     <= 1'b0;             // Hold falls with wait, never before [R1]
            hold_q     <= 1'b0;             // [R10] [R18]
            st_q       <= S_IDLE;
            idx_q      <= resp_idx;
            rdata_q    <= mem_q[resp_idx];  // Launched on the edge after address/hold [R4] [R5]
            rdata_oe_q <= !resp_wr;
         end else begin
            case (st_q)
               S_IDLE: begin
                  if (sel) begin
                     idx_q  <= aidx;
                     wr_q   <= dir;
                     wait_q <= 1'b1;
                     hold_q <= (USE_HOLD != 0);  // Hold entered at once, no later wait-only [R2] [R21]
                     cnt_q  <= WAIT_LAST;
                     st_q   <= S_BUSY;
                  end
               end
               S_BUSY: cnt_q <= cnt_q - 8'h01;
               default: st_q <= S_IDLE;
            endcase
         end
      end
   end

   // Write data is stable by the falling edge after the response
   always @(posedge clk) begin
      if (srst)
         wr_pend_q <= 1'b0;
      else if (resp_now)
         wr_pend_q <= resp_wr;
      else if (fall)
         wr_pend_q <= 1'b0;
   end

   genvar i;
   generate
      for (i = 0; i < DEPTH; i = i + 1) begin : g_word
         always @(posedge clk) begin
            if (srst)
               mem_q[i] <= 32'h0;
            else if (fall && wr_pend_q && (idx_q == i))
               mem_q[i] <= data_in;
         end
      end
   endgenerate

endmodule

// [rtl/ext_bus_agent.v]
// Contract
// R1: Slave holds the address-hold response until its wait response has dropped.
// R2: Within a cycle a slave never goes from address-hold back to plain wait.
// R3: Current master drives direction high for writes, low for reads.
// R4: Read data launched on rising edge after address ends, sampled next falling edge.
// R5: After an address-hold response, data launched next rising edge, sampled next fall.
// R6: Master launches write data one bus clock after the address.
// R7: Bus clock keeps toggling throughout the core reset low period.
// R8: Arbiter priority: bus hold, refresh, DMA, operand access, instruction fetch.
// R9: On an external request the arbiter waits for slave ready before handover.
// R10: Slave gives ready once the running transfer has fully completed.
// R11: During handover the device drives address-only; its selects are don't-care.
// R12: Grant comes with ready; external master then drives lock and selects inactive.
// R13: External master transfers only after it has received the grant.
// R14: External master drops its request to return the bus; arbiter awaits ready.
// R15: While returning, external master drives address-only; its selects are ignored.
// R16: On regaining, device drops grant, gives ready, holds lock and selects inactive.
// R17: After the return handshake the device resumes its own transfers.
// R18: Ready means wait, address-hold and last responses all low together.
// R19: Device does misaligned accesses only while the misalign strap is high.
// R20: Kind codes: 00 address-only, 10 non-sequential, 11 sequential, 01 reserved.
// R21: Status: wait alone, wait plus hold, last alone; other codes reserved.
// R22: Slave status is valid only in the low phase of the bus clock.
// R23: Grant stays up while the external request stays and nothing else changes.
`timescale 1ns/1ps
`include "bus_agent_consts.vh"

module ext_bus_agent #(
   parameter MISALIGN_EN = 0,
   parameter SLV_WAITS   = `SLV_WAITS_DEF,
   parameter SLV_HOLD    = 1,
   parameter SLV_DEPTH   = `SLV_DEPTH_DEF,
   parameter SLV_AW      = `SLV_AW_DEF,
   parameter SLV_BANK    = 0
) (
   input  wire        CLK,
   input  wire        SRST,
   // User side of the external master
   input  wire        USER_WANT,
   input  wire        USER_CMD_VALID,
   input  wire        USER_CMD_WRITE,
   input  wire [2:0]  USER_CMD_BANK,
   input  wire [27:0] USER_CMD_ADDR,
   input  wire [31:0] USER_CMD_WDATA,
   output reg         USER_CMD_TAKEN,
   output reg         USER_DONE,
   output reg  [31:0] USER_RDATA,
   output reg         USER_OWNER,
   // System pins
   output reg         SYS_BUS_CLOCK,
   output reg         CORE_RESET_LOW,
   output reg         MISALIGN_ENABLE_STRAP,
   // Ownership handshake
   output reg         BUS_OWN_REQUEST,
   input  wire        BUS_OWN_GRANT,
   // Shared control lines, driven while CTRL_OE is high
   input  wire        TRANSFER_KIND_HI_IN,
   input  wire        TRANSFER_KIND_LO_IN,
   input  wire        WRITE_DIRECTION_IN,
   input  wire [27:0] SYS_ADDRESS_LINES_IN,
   input  wire [7:0]  BANK_CHIP_SELECTS_IN,
   output reg         TRANSFER_KIND_HI_OUT,
   output reg         TRANSFER_KIND_LO_OUT,
   output reg         WRITE_DIRECTION_OUT,
   output reg  [27:0] SYS_ADDRESS_LINES_OUT,
   output reg  [7:0]  BANK_CHIP_SELECTS_OUT,
   output reg         BUS_LOCKED_CYCLE_OUT,
   output reg         PERIPH_SELECT_LOW_OUT,
   output reg         CTRL_OE,
   // Data bus
   input  wire [31:0] BUS_DATA_IN,
   output reg  [31:0] MST_DATA_OUT,
   output reg         MST_DATA_OE,
   output wire [31:0] SLV_DATA_OUT,
   output wire        SLV_DATA_OE,
   // Slave status
   output wire        WAIT_RESP,
   output wire        ADDR_HOLD_RESP,
   output wire        LAST_RESP
);

   localparam [5:0] M_IDLE = 6'h01;
   localparam [5:0] M_REQ  = 6'h02;
   localparam [5:0] M_OWN  = 6'h04;
   localparam [5:0] M_ADDR = 6'h08;
   localparam [5:0] M_DATA = 6'h10;
   localparam [5:0] M_REL  = 6'h20;

   reg  [5:0]                 st_q;
   reg  [`CORE_RST_CNT_W-1:0] rst_cnt_q;
   reg  [31:0]                samp_q;

   // Bus clock is CLK/2; rise and fall mark the CLK edges that make its edges
   wire rise = !SYS_BUS_CLOCK;
   wire fall = SYS_BUS_CLOCK;

   // Slave status decode; reserved codes count as wait, never as an end
   reg  status_ready;
   reg  status_last;
   always @* begin
      status_ready = 1'b0;
      status_last  = 1'b0;
      case ({WAIT_RESP, ADDR_HOLD_RESP, LAST_RESP})
         3'h0:    status_ready = 1'b1;                           // [R18]
         3'h1:    status_last  = 1'b1;                           // [R21]
         default: status_ready = 1'b0;                           // Wait, hold or reserved
      endcase
   end

   // Grant comes in from device pins; counted once stages two and three agree
   reg  [2:0] grant_sync_q;
   reg        grant_q;
   always @(posedge CLK) begin
      if (SRST) begin
         grant_sync_q <= 3'h0;
         grant_q      <= 1'b0;
      end else begin
         grant_sync_q <= {grant_sync_q[1:0], BUS_OWN_GRANT};
         if (grant_sync_q[1] == grant_sync_q[2])
            grant_q <= grant_sync_q[2];
      end
   end

   // Bus clock divider; never stops once our own reset is released
   always @(posedge CLK) begin
      if (SRST)
         SYS_BUS_CLOCK <= 1'b0;
      else
         SYS_BUS_CLOCK <= !SYS_BUS_CLOCK;                        // [R7]
   end

   // Core reset stretch counted in bus clocks; clock runs on through it
   always @(posedge CLK) begin
      if (SRST) begin
         CORE_RESET_LOW <= 1'b0;
         rst_cnt_q      <= `CORE_RST_BUS_CLKS;
      end else if (rise) begin
         if (rst_cnt_q != {`CORE_RST_CNT_W{1'b0}})
            rst_cnt_q <= rst_cnt_q - {{(`CORE_RST_CNT_W-1){1'b0}}, 1'b1};
         else
            CORE_RESET_LOW <= 1'b1;                              // [R7]
      end
   end

   // Strap is a build option, so it only needs setting in reset
   always @(posedge CLK) begin
      if (SRST)
         MISALIGN_ENABLE_STRAP <= (MISALIGN_EN != 0);            // [R19]
   end

   // One strobe per sequencer step; all fall on bus clock rising edges
   wire step    = rise && CORE_RESET_LOW;
   wire do_ask  = step && (st_q == M_IDLE) && USER_WANT;
   wire do_take = step && (st_q == M_REQ) && grant_q;                      // [R9] [R13]
   wire do_drop = step && (st_q == M_OWN) && !USER_WANT;                   // [R14]
   wire do_cmd  = step && (st_q == M_OWN) && USER_WANT && USER_CMD_VALID;
   wire do_addr = step && (st_q == M_ADDR);
   wire do_end  = step && (st_q == M_DATA) && (status_ready || status_last); // [R22] [R18]
   wire do_free = step && (st_q == M_REL) && !grant_q;                     // [R16]

   // External master sequencer state
   always @(posedge CLK) begin
      if (SRST) begin
         st_q <= M_IDLE;
      end else if (step) begin
         case (st_q)
            // Idle until the user asks for the bus
            M_IDLE: begin
               if (USER_WANT)
                  st_q <= M_REQ;
            end

            // Request held until granted, even if the user has lost interest
            M_REQ: begin
               if (grant_q)
                  st_q <= M_OWN;
            end

            // Release wins over a waiting command
            M_OWN: begin
               if (!USER_WANT)
                  st_q <= M_REL;
               else if (USER_CMD_VALID)
                  st_q <= M_ADDR;
            end

            // Address phase lasts one bus clock
            M_ADDR: st_q <= M_DATA;

            // Status seen here was driven in the low phase just ended
            M_DATA: begin
               if (status_ready || status_last)
                  st_q <= M_OWN;
            end

            // Lines stay driven idle until the device takes the bus back
            M_REL: begin
               if (!grant_q)
                  st_q <= M_IDLE;
            end

            default: st_q <= M_IDLE;
         endcase
      end
   end

   // Ownership handshake and user strobes
   always @(posedge CLK) begin
      if (SRST) begin
         BUS_OWN_REQUEST <= 1'b0;
         USER_OWNER      <= 1'b0;
         CTRL_OE         <= 1'b0;
         USER_CMD_TAKEN  <= 1'b0;
         USER_DONE       <= 1'b0;
         USER_RDATA      <= 32'h0;
      end else begin
         USER_CMD_TAKEN <= do_cmd;
         USER_DONE      <= do_end;
         if (do_ask)
            BUS_OWN_REQUEST <= 1'b1;
         else if (do_drop)
            BUS_OWN_REQUEST <= 1'b0;                             // [R14]
         if (do_take) begin
            CTRL_OE    <= 1'b1;                                  // [R13]
            USER_OWNER <= 1'b1;
         end else if (do_free) begin
            CTRL_OE    <= 1'b0;                                  // [R16]
            USER_OWNER <= 1'b0;
         end
         if (do_end && !WRITE_DIRECTION_OUT)
            USER_RDATA <= samp_q;                                // [R4] [R5]
      end
   end

   // Address-phase lines; kept idle whenever no command of ours is out
   always @(posedge CLK) begin
      if (SRST) begin
         TRANSFER_KIND_HI_OUT  <= 1'b0;
         TRANSFER_KIND_LO_OUT  <= 1'b0;
         WRITE_DIRECTION_OUT   <= 1'b0;
         SYS_ADDRESS_LINES_OUT <= 28'h0;
         BANK_CHIP_SELECTS_OUT <= `CS_ALL_IDLE;
         BUS_LOCKED_CYCLE_OUT  <= `LOCK_IDLE;
         PERIPH_SELECT_LOW_OUT <= `PSEL_IDLE;
      end else if (do_cmd) begin
         {TRANSFER_KIND_HI_OUT, TRANSFER_KIND_LO_OUT} <= `KIND_NONSEQ;     // [R20]
         WRITE_DIRECTION_OUT   <= USER_CMD_WRITE;                 // [R3]
         SYS_ADDRESS_LINES_OUT <= USER_CMD_ADDR;
         BANK_CHIP_SELECTS_OUT <= ~(`CS_ONE_HOT << USER_CMD_BANK);
      end else if (do_take || do_drop || do_addr) begin
         // Taking, returning or past the address: address-only, all selects idle
         {TRANSFER_KIND_HI_OUT, TRANSFER_KIND_LO_OUT} <= `KIND_ADDR_ONLY;  // [R15]
         BANK_CHIP_SELECTS_OUT <= `CS_ALL_IDLE;                   // [R12]
         BUS_LOCKED_CYCLE_OUT  <= `LOCK_IDLE;                     // [R12]
         PERIPH_SELECT_LOW_OUT <= `PSEL_IDLE;                     // [R12]
      end
   end

   // Write data launched one bus clock after the address, dropped at the end
   always @(posedge CLK) begin
      if (SRST) begin
         MST_DATA_OUT <= 32'h0;
         MST_DATA_OE  <= 1'b0;
      end else if (do_cmd) begin
         MST_DATA_OUT <= USER_CMD_WDATA;
      end else if (do_addr) begin
         MST_DATA_OE  <= WRITE_DIRECTION_OUT;                     // [R6]
      end else if (do_end) begin
         MST_DATA_OE  <= 1'b0;
      end
   end

   // Read data sampled on each data-phase falling edge; the last one before ready counts
   always @(posedge CLK) begin
      if (SRST)
         samp_q <= 32'h0;
      else if (fall && (st_q == M_DATA) && !WRITE_DIRECTION_OUT)
         samp_q <= BUS_DATA_IN;                                   // [R4] [R5]
   end

   // Slave answering whichever master owns the bus
   bus_slave_resp #(
      .WAITS    (SLV_WAITS),
      .USE_HOLD (SLV_HOLD),
      .DEPTH    (SLV_DEPTH),
      .AW       (SLV_AW),
      .BANK     (SLV_BANK)
   ) u_slave (
      .clk        (CLK),
      .srst       (SRST),
      .rise       (rise),
      .fall       (fall),
      .kind       ({TRANSFER_KIND_HI_IN, TRANSFER_KIND_LO_IN}),
      .dir        (WRITE_DIRECTION_IN),
      .addr       (SYS_ADDRESS_LINES_IN),
      .cs_n       (BANK_CHIP_SELECTS_IN),
      .data_in    (BUS_DATA_IN),
      .wait_q     (WAIT_RESP),
      .hold_q     (ADDR_HOLD_RESP),
      .last_q     (LAST_RESP),
      .rdata_q    (SLV_DATA_OUT),
      .rdata_oe_q (SLV_DATA_OE)
   );

endmodule

// [tb/bus_device_model.sv]
`timescale 1ns/1ps

module bus_device_model #(
   parameter LAG = 0
) (
   input  wire       sbc,
   input  wire       rst_n,
   input  wire       req,
   input  wire       wait_r,
   input  wire       hold_r,
   input  wire       last_r,
   output reg        grant_q,
   output wire [1:0] kind,
   output wire [7:0] cs_n
);
   reg  [3:0] lag_q;
   wire       ready = !wait_r && !hold_r && !last_r;

   // Status is only valid in the low phase, so act on the falling bus clock
   always @(negedge sbc or negedge rst_n) begin
      if (!rst_n) begin
         grant_q <= 1'b0;
         lag_q <= 4'h0;
      end else if (req == grant_q) begin
         lag_q <= 4'h0; // Grant held while request stands
      end else if (lag_q < LAG) begin
         lag_q <= lag_q + 4'h1; // Own cycle must finish; bus hold outranks the rest
      end else if (ready) begin
         grant_q <= req; // Hand over or take back only on ready
      end
   end

   // Own lines idle: address-only, no select, whether handing over or back
   assign kind = 2'h0;
   assign cs_n = 8'hFF;
endmodule

// [tb/ext_bus_agent_properties.sv]
`timescale 1ns/1ps

module ext_bus_agent_checker (
   input wire CLK,
   input wire SRST,
   input wire USER_CMD_WRITE,
   input wire USER_OWNER,
   input wire USER_DONE,
   input wire BUS_OWN_REQUEST,
   input wire BUS_OWN_GRANT,
   input wire TRANSFER_KIND_HI_OUT,
   input wire TRANSFER_KIND_LO_OUT,
   input wire WRITE_DIRECTION_OUT,
   input wire WRITE_DIRECTION_IN,
   input wire CTRL_OE,
   input wire MST_DATA_OE,
   input wire SLV_DATA_OE,
   input wire WAIT_RESP,
   input wire ADDR_HOLD_RESP,
   input wire LAST_RESP
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);

   chk_hold_until_wait: assert property ($fell(ADDR_HOLD_RESP) |-> !WAIT_RESP)
      else $error("hold dropped while wait still high");
   chk_no_wait_after_hold: assert property ($past(ADDR_HOLD_RESP) && WAIT_RESP |-> ADDR_HOLD_RESP)
      else $error("wait alone after hold");
   chk_status_legal: assert property (!(ADDR_HOLD_RESP && !WAIT_RESP) && !(LAST_RESP && (WAIT_RESP || ADDR_HOLD_RESP)))
      else $error("reserved status code");
   chk_write_data_edge: assert property ($rose(TRANSFER_KIND_HI_OUT) && WRITE_DIRECTION_OUT |-> !MST_DATA_OE ##2 MST_DATA_OE)
      else $error("write data not one bus clock after address");
   chk_read_after_hold: assert property ($fell(ADDR_HOLD_RESP) && !WRITE_DIRECTION_IN |-> SLV_DATA_OE)
      else $error("read data not launched after hold");
   chk_read_data_window: assert property ($rose(SLV_DATA_OE) |-> ##1 SLV_DATA_OE ##1 (!SLV_DATA_OE && USER_DONE))
      else $error("read data window or sample wrong");
   chk_xfer_when_owned: assert property ($rose(TRANSFER_KIND_HI_OUT) |-> CTRL_OE && USER_OWNER && BUS_OWN_GRANT)
      else $error("transfer without grant");
   chk_dir_from_cmd: assert property ($rose(TRANSFER_KIND_HI_OUT) |-> WRITE_DIRECTION_OUT == $past(USER_CMD_WRITE))
      else $error("direction does not match command");
   chk_return_addr_only: assert property ($fell(BUS_OWN_REQUEST) |-> CTRL_OE && !TRANSFER_KIND_HI_OUT && !TRANSFER_KIND_LO_OUT)
      else $error("return not address-only");
   chk_return_bounded: assert property ($fell(BUS_OWN_REQUEST) |-> ##[1:24] !CTRL_OE)
      else $error("bus not released after request drop");

   cover property ($rose(MST_DATA_OE));
   cover property ($rose(SLV_DATA_OE));
   cover property ($fell(BUS_OWN_GRANT));
endmodule

bind ext_bus_agent ext_bus_agent_checker u_chk (.*);

// [tb/ext_bus_agent_tb.sv]
`timescale 1ns/1ps

module ext_bus_agent_tb;
   localparam W = 2;
   logic        clk, srst, want, valid, wr;
   logic [27:0] addr;
   logic [31:0] wdata;
   int          n_fail, cmp_count, lat;
   wire         taken, done, owner, sbc, core_rst_n, strap, req, grant, khi, klo, dir_o;
   wire         lock, psel_n, oe, mst_oe, slv_oe, wait_r, hold_r, last_r;
   wire [27:0]  addr_o;
   wire [7:0]   cs_o, dev_cs;
   wire [31:0]  rdata, mst_d, slv_d;
   wire [1:0]   dev_kind;
   // Undriven wires show the inverse of the master's own outputs, not a settled guess
   wire [31:0]  bus_d = mst_oe ? mst_d : (slv_oe ? slv_d : ~mst_d);
   wire [1:0]   kind_w = oe ? {khi, klo} : dev_kind;

   ext_bus_agent #(.SLV_WAITS(W)) DUT (.CLK(clk), .SRST(srst), .USER_WANT(want),
      .USER_CMD_VALID(valid), .USER_CMD_WRITE(wr), .USER_CMD_BANK(3'h0),
      .USER_CMD_ADDR(addr), .USER_CMD_WDATA(wdata), .USER_CMD_TAKEN(taken),
      .USER_DONE(done), .USER_RDATA(rdata), .USER_OWNER(owner), .SYS_BUS_CLOCK(sbc),
      .CORE_RESET_LOW(core_rst_n), .MISALIGN_ENABLE_STRAP(strap), .BUS_OWN_REQUEST(req),
      .BUS_OWN_GRANT(grant), .TRANSFER_KIND_HI_IN(kind_w[1]), .TRANSFER_KIND_LO_IN(kind_w[0]),
      .WRITE_DIRECTION_IN(oe ? dir_o : ~dir_o), .SYS_ADDRESS_LINES_IN(oe ? addr_o : ~addr_o),
      .BANK_CHIP_SELECTS_IN(oe ? cs_o : dev_cs), .TRANSFER_KIND_HI_OUT(khi),
      .TRANSFER_KIND_LO_OUT(klo), .WRITE_DIRECTION_OUT(dir_o), .SYS_ADDRESS_LINES_OUT(addr_o),
      .BANK_CHIP_SELECTS_OUT(cs_o), .BUS_LOCKED_CYCLE_OUT(lock), .PERIPH_SELECT_LOW_OUT(psel_n),
      .CTRL_OE(oe), .BUS_DATA_IN(bus_d), .MST_DATA_OUT(mst_d), .MST_DATA_OE(mst_oe),
      .SLV_DATA_OUT(slv_d), .SLV_DATA_OE(slv_oe), .WAIT_RESP(wait_r),
      .ADDR_HOLD_RESP(hold_r), .LAST_RESP(last_r));

   bus_device_model #(.LAG(3)) u_dev (.sbc(sbc), .rst_n(core_rst_n), .req(req),
      .wait_r(wait_r), .hold_r(hold_r), .last_r(last_r), .grant_q(grant),
      .kind(dev_kind), .cs_n(dev_cs));

   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   // A bound that runs out ends the run at once
   task automatic tmo(input string nm, input logic ok);
      check(nm, ok, 1);
      if (ok !== 1'b1) end_sim;
   endtask

   task automatic xfer(input logic w, input logic [27:0] a, input logic [31:0] d);
      int k;
      wr = w;
      addr = a;
      wdata = d;
      valid = 1'b1;
      for (k = 0; k < 20 && taken !== 1'b1; k++) @(negedge clk);
      tmo("cmd_taken", taken);
      valid = 1'b0;
      for (k = 0; k < 40 && done !== 1'b1; k++) @(negedge clk);
      tmo("user_done", done);
      lat = k;
   endtask

   task automatic own(input logic on);
      int k;
      want = on;
      for (k = 0; k < 80 && owner !== on; k++) @(negedge clk);
      tmo("owner", owner === on);
   endtask

   task automatic test_reset;
      int k, n;
      logic prev;
      check("cs_reset", cs_o, 8'hFF);
      check("strap", strap, 1'b0);
      check("oe_reset", oe, 1'b0);
      prev = sbc;
      n = 0;
      for (k = 0; k < 200 && core_rst_n !== 1'b1; k++) begin
         @(negedge clk);
         if (sbc !== prev) n++;
         prev = sbc;
      end
      tmo("core_reset_end", core_rst_n);
      check("clk_in_reset", n >= 30, 1'b1);
      $display("test reset done");
   endtask

   task automatic test_own;
      own(1'b1);
      check("request", req, 1'b1);
      check("idle_kind", kind_w, 2'h0);
      check("idle_cs", cs_o, 8'hFF);
      check("idle_lock", lock, 1'b0);
      check("idle_psel", psel_n, 1'b1);
      $display("test own done");
   endtask

   // Back-to-back writes, then reads back through hold and wait states
   task automatic test_rw;
      xfer(1'b1, 28'h0000004, 32'hA5C30F1E);
      check("wr_latency", lat, 2 * (2 + W));
      xfer(1'b1, 28'h0000008, 32'h5A3CF0E1);
      xfer(1'b0, 28'h0000004, 32'h0);
      check("rd_data_a", rdata, 32'hA5C30F1E);
      check("rd_latency", lat, 2 * (2 + W));
      xfer(1'b0, 28'h0000008, 32'h0);
      check("rd_data_b", rdata, 32'h5A3CF0E1);
      $display("test rw done");
   endtask

   task automatic test_release;
      own(1'b0);
      check("req_off", req, 1'b0);
      check("oe_off", oe, 1'b0);
      check("grant_off", grant, 1'b0);
      own(1'b1);
      xfer(1'b0, 28'h0000008, 32'h0);
      check("rd_again", rdata, 32'h5A3CF0E1);
      own(1'b0);
      $display("test release done");
   endtask

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      srst = 1'b1;
      want = 1'b0;
      valid = 1'b0;
      wr = 1'b0;
      addr = 28'h0;
      wdata = 32'h0;
      n_fail = 0;
      cmp_count = 0;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      test_reset;
      test_own;
      test_rw;
      test_release;
      end_sim;
   end
endmodule
